/* File: rtl/transceiver_control_registers.sv */
// Purpose: control register bank with 4x10 data queue, reached over a serial host port
// Assumes: host keeps the pause HOST_WAIT_CYCLES after a read address byte and after a write frame
// Notes: serial logic runs on sclk, the bank and queue on clock; words cross quasi-statically
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - four deep ten bit queue behind data register
// - command bits stored, pushed with next data write
// - full flag reads one at four words
// - empty read attempt sets underrun flag
// - full write attempt sets overrun flag
// - control read returns flags, then clears the error flags
// - head word status shown at bits 7:6
// - power bit seven holds chip in reset
// - four bit power mode field, reset zero
// - fixed read only silicon revision code
// - scratch register fixed, no chip effect
// - crystal gm setting drives oscillator gain
module transceiver_control_registers #(
  parameter logic [7:0] SILICON_REVISION = 8'h5A // arbitrary value
)(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic selB,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  input wire logic txMode,
  input wire logic engineWrite,
  input wire logic [9:0] engineWord,
  input wire logic engineRead,
  input wire transceiver_regs_pkg::trackValues_t trackValues,
  output transceiver_regs_pkg::trims_t trims,
  output logic chipReset,
  output logic [9:0] headWord,
  output logic queueEmpty,
  output logic queueFull
);
  import transceiver_regs_pkg::*;

  // serial frame state, cleared whenever select is high
  typedef struct packed {
    logic [4:0] bitCnt;
    logic [6:0] shiftIn;
    logic isWrite;
    logic [6:0] addr;
    logic [6:0] shiftOut;
    logic miso;
    logic misoOe;
  } frameState_t;

  // requests handed to the core, must outlive the frame
  typedef struct packed {
    logic [6:0] wrAddr;
    logic [7:0] wrData;
    logic wrToggle;
    logic [6:0] rdAddr;
    logic rdToggle;
  } holdState_t;

  // core state on clock
  typedef struct packed {
    logic [2:0] wrSync;
    logic wrSeen;
    logic [2:0] rdSync;
    logic rdSeen;
    logic [7:0] crystal_tuning_cap;
    logic [7:0] vcoCurrent;
    logic [7:0] loCurrent;
    logic [7:0] refAdjust;
    logic [7:0] rx_misc_settings;
    logic [3:0] gmSetting;
    logic resetBit;
    logic [3:0] powerState;
    logic [1:0] cmd;
    logic under;
    logic over;
    logic [QUEUE_DEPTH-1:0][QUEUE_WIDTH-1:0] mem;
    logic [2:0] wrPtr;
    logic [2:0] rdPtr;
    logic [7:0] rdData;
    logic [9:0] headWord;
    logic empty;
    logic full;
  } coreState_t;

  localparam coreState_t CORE_RESET = '{
    crystal_tuning_cap: RST_XTAL_CAP, vcoCurrent: RST_VCO_TRIM, loCurrent: RST_LO_CURRENT,
    refAdjust: RST_REF_ADJUST, rx_misc_settings: RST_RX_MISC, gmSetting: RST_GM_SETTING,
    powerState: RST_POWER_STATE, cmd: RST_QUEUE_CMD, empty: 1'b1, default: '0};

  frameState_t frame_reg;
  frameState_t frame_next;
  holdState_t hold_reg;
  holdState_t hold_next;
  coreState_t core_reg;
  coreState_t core_next;
  logic frameRst_b; // frame reset: rst_b low or select high
  logic wrEvent; // host write request arrived, one cycle
  logic rdEvent; // host read request arrived, one cycle

  // queue pointers carry a wrap bit so that four words differ from none
  function automatic logic [2:0] queueCount(input logic [2:0] wrPtr, input logic [2:0] rdPtr);
    queueCount = 3'(wrPtr - rdPtr);
  endfunction

  // select high drops any half frame; the host raises it before a chip reset write
  assign frameRst_b = rst_b & ~selB;

  // serial shifter: address byte (write flag first), then data byte
  always_comb
  begin
    frame_next = frame_reg;
    hold_next = hold_reg;
    if (frame_reg.bitCnt != FRAME_BITS) // extra clocks past a frame are ignored
    begin
      frame_next.bitCnt = 5'(frame_reg.bitCnt + 5'h01);
    end
    frame_next.shiftIn = {frame_reg.shiftIn[5:0], mosi};
    if (frame_reg.bitCnt == 5'h07)
    begin
      // address byte complete
      frame_next.isWrite = frame_reg.shiftIn[6];
      frame_next.addr = {frame_reg.shiftIn[5:0], mosi};
      if (!frame_reg.shiftIn[6])
      begin
        // reads are launched now so the core can fetch during the host pause
        hold_next.rdAddr = {frame_reg.shiftIn[5:0], mosi};
        hold_next.rdToggle = ~hold_reg.rdToggle;
      end
    end
    else if (frame_reg.bitCnt == 5'h08 && !frame_reg.isWrite)
    begin
      // rdData is stable by now because the host paused; no sync on purpose
      frame_next.miso = core_reg.rdData[7];
      frame_next.shiftOut = core_reg.rdData[6:0];
      frame_next.misoOe = 1'b1;
    end
    else if (frame_reg.bitCnt > 5'h08 && frame_reg.bitCnt < FRAME_BITS && !frame_reg.isWrite)
    begin
      // shift out the remaining read bits, msb first
      frame_next.miso = frame_reg.shiftOut[6];
      frame_next.shiftOut = {frame_reg.shiftOut[5:0], 1'b0};
    end
    else if (frame_reg.bitCnt == 5'h0F && frame_reg.isWrite)
    begin
      // data byte complete: hand the write to the core
      hold_next.wrAddr = frame_reg.addr;
      hold_next.wrData = {frame_reg.shiftIn, mosi};
      hold_next.wrToggle = ~hold_reg.wrToggle;
    end
  end

  // frame registers: cleared by select, since sclk stops between frames
  always_ff @(posedge sclk or negedge frameRst_b)
  begin
    if (!frameRst_b)
      frame_reg <= '0;
    else
      frame_reg <= frame_next;
  end

  // handed-over requests survive select so the core can still read them
  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
      hold_reg <= '0;
    else
      hold_reg <= hold_next;
  end

  // a toggle counts once the second and third sync stages agree
  assign wrEvent = (core_reg.wrSync[1] == core_reg.wrSync[2]) && (core_reg.wrSync[2] != core_reg.wrSeen);
  assign rdEvent = (core_reg.rdSync[1] == core_reg.rdSync[2]) && (core_reg.rdSync[2] != core_reg.rdSeen);

  // core: register writes and reads, queue push and pop, flags
  always_comb
  begin
    logic pushReq;
    logic popReq;
    logic [9:0] pushWord;
    logic setUnder;
    logic setOver;
    logic clearFlags;
    coreState_t kept;
    pushReq = 1'b0;
    popReq = 1'b0;
    pushWord = '0;
    setUnder = 1'b0;
    setOver = 1'b0;
    clearFlags = 1'b0;
    kept = '0;
    core_next = core_reg;
    core_next.wrSync = {core_reg.wrSync[1:0], hold_reg.wrToggle};
    core_next.rdSync = {core_reg.rdSync[1:0], hold_reg.rdToggle};
    if (wrEvent)
    begin
      core_next.wrSeen = core_reg.wrSync[2];
      unique case (hold_reg.wrAddr)
        ADDR_POWER:
        begin
          core_next.resetBit = hold_reg.wrData[POWER_RESET_BIT];
          core_next.powerState = hold_reg.wrData[3:0];
        end
        ADDR_CRYSTAL_GM_CONTROL: core_next.gmSetting = hold_reg.wrData[3:0];
        ADDR_QCTRL: core_next.cmd = hold_reg.wrData[1:0];
        ADDR_QDATA:
        begin
          // the host only writes the queue while transmitting
          if (txMode)
          begin
            pushReq = 1'b1;
            pushWord = {core_reg.cmd, hold_reg.wrData};
          end
        end
        ADDR_XTAL_CAP: core_next.crystal_tuning_cap = hold_reg.wrData;
        ADDR_VCO_TRIM: core_next.vcoCurrent = hold_reg.wrData;
        ADDR_LO_CURRENT: core_next.loCurrent = hold_reg.wrData;
        ADDR_REF_ADJUST: core_next.refAdjust = hold_reg.wrData;
        ADDR_RX_MISC: core_next.rx_misc_settings = hold_reg.wrData;
        // read-only and unmapped addresses ignore writes
        default: core_next.cmd = core_reg.cmd;
      endcase
    end
    if (rdEvent)
    begin
      core_next.rdSeen = core_reg.rdSync[2];
      unique case (hold_reg.rdAddr)
        ADDR_REVISION: core_next.rdData = SILICON_REVISION;
        ADDR_SCRATCH: core_next.rdData = RST_SCRATCH;
        ADDR_POWER: core_next.rdData = {core_reg.resetBit, 3'h0, core_reg.powerState};
        ADDR_CRYSTAL_GM_CONTROL: core_next.rdData = {4'h0, core_reg.gmSetting};
        ADDR_QCTRL:
        begin
          // return what accumulated, then clear the error flags
          core_next.rdData = {core_reg.headWord[9:8], core_reg.over, core_reg.under,
                              core_reg.full, core_reg.empty, core_reg.cmd};
          clearFlags = 1'b1;
        end
        ADDR_QDATA:
        begin
          core_next.rdData = core_reg.empty ? 8'h00 : core_reg.headWord[7:0];
          // the host only reads the queue while receiving
          if (!txMode)
            popReq = 1'b1;
        end
        ADDR_TRK_AMP_LO: core_next.rdData = trackValues.ampLo;
        ADDR_TRK_PHASE_HI: core_next.rdData = trackValues.phaseHi;
        ADDR_TRK_PHASE_LO: core_next.rdData = trackValues.phaseLo;
        ADDR_TRK_FREQ_HI: core_next.rdData = trackValues.freqHi;
        ADDR_TRK_FREQ_LO: core_next.rdData = trackValues.freqLo;
        ADDR_XTAL_CAP: core_next.rdData = core_reg.crystal_tuning_cap;
        ADDR_VCO_TRIM: core_next.rdData = core_reg.vcoCurrent;
        ADDR_LO_CURRENT: core_next.rdData = core_reg.loCurrent;
        ADDR_REF_ADJUST: core_next.rdData = core_reg.refAdjust;
        ADDR_RX_MISC: core_next.rdData = core_reg.rx_misc_settings;
        default: core_next.rdData = 8'h00; // unmapped addresses read as zero
      endcase
    end
    // the engine writes while receiving and reads while transmitting
    if (engineWrite && !txMode)
    begin
      pushReq = 1'b1;
      pushWord = engineWord;
    end
    if (engineRead && txMode)
      popReq = 1'b1;
    // a refused pop or push only raises its flag
    if (popReq && core_reg.empty)
      setUnder = 1'b1;
    if (pushReq && core_reg.full)
      setOver = 1'b1;
    if (pushReq && !core_reg.full)
    begin
      core_next.mem[core_reg.wrPtr[1:0]] = pushWord;
      core_next.wrPtr = 3'(core_reg.wrPtr + 3'h1);
    end
    if (popReq && !core_reg.empty)
      core_next.rdPtr = 3'(core_reg.rdPtr + 3'h1);
    // a new error in the clearing cycle wins over the clear
    core_next.under = (core_reg.under & ~clearFlags) | setUnder;
    core_next.over = (core_reg.over & ~clearFlags) | setOver;
    // the chip reset bit holds all but the power field, read data and crossing state at reset value
    if (core_next.resetBit)
    begin
      kept = core_next;
      core_next = CORE_RESET;
      core_next.wrSync = kept.wrSync;
      core_next.wrSeen = kept.wrSeen;
      core_next.rdSync = kept.rdSync;
      core_next.rdSeen = kept.rdSeen;
      core_next.rdData = kept.rdData;
      core_next.powerState = kept.powerState;
      core_next.resetBit = 1'b1;
    end
    // status views of the queue, registered so outputs come from flops
    core_next.empty = (queueCount(core_next.wrPtr, core_next.rdPtr) == 3'h0);
    core_next.full = (queueCount(core_next.wrPtr, core_next.rdPtr) == 3'(QUEUE_DEPTH));
    core_next.headWord = core_next.mem[core_next.rdPtr[1:0]];
  end

  // core registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      core_reg <= CORE_RESET;
    else
      core_reg <= core_next;
  end

  // outputs, all straight from flops
  assign miso = frame_reg.miso;
  assign misoOe = frame_reg.misoOe;
  assign trims = '{crystal_tuning_cap: core_reg.crystal_tuning_cap, vcoCurrent: core_reg.vcoCurrent, loCurrent: core_reg.loCurrent,
                   refAdjust: core_reg.refAdjust, rx_misc_settings: core_reg.rx_misc_settings, gmSetting: core_reg.gmSetting,
                   powerState: core_reg.powerState};
  assign chipReset = core_reg.resetBit;
  assign headWord = core_reg.headWord;
  assign queueEmpty = core_reg.empty;
  assign queueFull = core_reg.full;

  // helper: host reads and writes decoded by address
  logic hostPop;
  logic hostPush;
  logic ctrlRead;
  assign hostPop = rdEvent && hold_reg.rdAddr == ADDR_QDATA && !txMode;
  assign hostPush = wrEvent && hold_reg.wrAddr == ADDR_QDATA && txMode;
  assign ctrlRead = rdEvent && hold_reg.rdAddr == ADDR_QCTRL;

  // a pop attempt on an empty queue while out of chip reset
  sequence s_emptyPop;
    (hostPop || (engineRead && txMode)) && core_reg.empty && !core_next.resetBit;
  endsequence

  // an accepted host push: stored word is the command plus the data byte
  sequence s_hostPushOk;
    hostPush && !core_reg.full && !core_next.resetBit && !(engineWrite && !txMode);
  endsequence

  a_full_flag: assert property (@(posedge clock) disable iff (!rst_b)
    queueFull == (queueCount(core_reg.wrPtr, core_reg.rdPtr) == 3'h4))
    else $error("full flag does not match four stored words");

  a_empty_flag: assert property (@(posedge clock) disable iff (!rst_b)
    queueEmpty == (core_reg.wrPtr == core_reg.rdPtr))
    else $error("empty flag does not match queue count");

  a_underrun_set: assert property (@(posedge clock) disable iff (!rst_b)
    s_emptyPop |=> core_reg.under && $stable(core_reg.rdPtr))
    else $error("underrun not flagged on empty read");

  a_overrun_set: assert property (@(posedge clock) disable iff (!rst_b)
    (pushReq_probe() && core_reg.full && !core_next.resetBit) |=> core_reg.over && $stable(core_reg.wrPtr))
    else $error("overrun not flagged on full write");

  a_flags_clear: assert property (@(posedge clock) disable iff (!rst_b)
    (ctrlRead && !core_next.resetBit) |=> core_reg.rdData[QC_UNDER_BIT] == $past(core_reg.under)
      && core_reg.rdData[QC_OVER_BIT] == $past(core_reg.over) && (core_reg.under == $past(setUnderProbe())))
    else $error("control read did not return and clear error flags");

  a_head_status: assert property (@(posedge clock) disable iff (!rst_b)
    (ctrlRead && !core_next.resetBit) |=> core_reg.rdData[7:QC_STATUS_LSB] == $past(core_reg.headWord[9:8]))
    else $error("head status bits wrong in control read");

  a_cmd_pushed: assert property (@(posedge clock) disable iff (!rst_b)
    s_hostPushOk |=> core_reg.mem[$past(core_reg.wrPtr[1:0])] == {$past(core_reg.cmd), $past(hold_reg.wrData)})
    else $error("pushed word lacks stored command bits");

  a_chip_reset: assert property (@(posedge clock) disable iff (!rst_b)
    chipReset [*2] |-> queueEmpty && trims.gmSetting == RST_GM_SETTING && core_reg.cmd == RST_QUEUE_CMD)
    else $error("state not held at reset during chip reset");

  a_gm_write: assert property (@(posedge clock) disable iff (!rst_b)
    (wrEvent && hold_reg.wrAddr == ADDR_CRYSTAL_GM_CONTROL && !core_next.resetBit)
      |=> trims.gmSetting == $past(hold_reg.wrData[3:0]))
    else $error("gm setting not taken from write");

  a_revision_read: assert property (@(posedge clock) disable iff (!rst_b)
    (rdEvent && hold_reg.rdAddr == ADDR_REVISION) |=> core_reg.rdData == SILICON_REVISION)
    else $error("revision read returned wrong code");

  a_miso_read: assert property (@(posedge sclk) disable iff (!frameRst_b)
    misoOe |-> !frame_reg.isWrite && frame_reg.bitCnt > 5'h08)
    else $error("serial output driven outside read data phase");

  // probes used by assertions only: recompute push request and underrun set
  function automatic logic pushReq_probe();
    pushReq_probe = hostPush || (engineWrite && !txMode);
  endfunction
  function automatic logic setUnderProbe();
    setUnderProbe = (hostPop || (engineRead && txMode)) && core_reg.empty;
  endfunction
endmodule

`default_nettype wire

/* File: rtl/transceiver_regs_pkg.sv */
// Purpose: shared constants and carrier types of the transceiver control register bank
// Assumes: 7-bit register addresses, 8-bit register data, 10 MHz core clock
// Notes: offsets of the low control registers are fixed here, the upper map as printed
package transceiver_regs_pkg;
  // register addresses
  localparam logic [6:0] ADDR_REVISION = 7'h00;
  localparam logic [6:0] ADDR_SCRATCH = 7'h01;
  localparam logic [6:0] ADDR_POWER = 7'h02;
  localparam logic [6:0] ADDR_CRYSTAL_GM_CONTROL = 7'h03;
  localparam logic [6:0] ADDR_QCTRL = 7'h04;
  localparam logic [6:0] ADDR_QDATA = 7'h05;
  localparam logic [6:0] ADDR_TRK_AMP_LO = 7'h49;
  localparam logic [6:0] ADDR_TRK_PHASE_HI = 7'h4A;
  localparam logic [6:0] ADDR_TRK_PHASE_LO = 7'h4B;
  localparam logic [6:0] ADDR_TRK_FREQ_HI = 7'h4C;
  localparam logic [6:0] ADDR_TRK_FREQ_LO = 7'h4D;
  localparam logic [6:0] ADDR_XTAL_CAP = 7'h4F;
  localparam logic [6:0] ADDR_VCO_TRIM = 7'h72;
  localparam logic [6:0] ADDR_LO_CURRENT = 7'h7A;
  localparam logic [6:0] ADDR_REF_ADJUST = 7'h7C;
  localparam logic [6:0] ADDR_RX_MISC = 7'h7D;
  // reset values
  localparam logic [7:0] RST_XTAL_CAP = 8'h00;
  localparam logic [7:0] RST_VCO_TRIM = 8'h04;
  localparam logic [7:0] RST_LO_CURRENT = 8'h30;
  localparam logic [7:0] RST_REF_ADJUST = 8'h23;
  localparam logic [7:0] RST_RX_MISC = 8'h36;
  localparam logic [7:0] RST_SCRATCH = 8'hC5;
  localparam logic [3:0] RST_POWER_STATE = 4'h0;
  localparam logic [3:0] RST_GM_SETTING = 4'h2;
  localparam logic [1:0] RST_QUEUE_CMD = 2'h3;
  // field positions
  localparam int POWER_RESET_BIT = 7;
  localparam int QC_EMPTY_BIT = 2;
  localparam int QC_FULL_BIT = 3;
  localparam int QC_UNDER_BIT = 4;
  localparam int QC_OVER_BIT = 5;
  localparam int QC_STATUS_LSB = 6;
  // queue shape
  localparam int QUEUE_DEPTH = 4;
  localparam int QUEUE_WIDTH = 10;
  // serial frame: bit count of a whole frame
  localparam logic [4:0] FRAME_BITS = 5'h10;
  // host pause between address byte and data byte of a read, and between frames
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int HOST_WAIT_NS = 800;
  localparam int HOST_WAIT_CYCLES = (HOST_WAIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // values tracked by the receiver, read back only
  typedef struct packed {
    logic [7:0] ampLo;
    logic [7:0] phaseHi;
    logic [7:0] phaseLo;
    logic [7:0] freqHi;
    logic [7:0] freqLo;
  } trackValues_t;

  // settings steering the analog blocks
  typedef struct packed {
    logic [7:0] crystal_tuning_cap;
    logic [7:0] vcoCurrent;
    logic [7:0] loCurrent;
    logic [7:0] refAdjust;
    logic [7:0] rx_misc_settings;
    logic [3:0] gmSetting;
    logic [3:0] powerState;
  } trims_t;
endpackage

/* File: test/host_model.sv */
// Purpose: behavioural host that drives the serial register port in whole frames
// Assumes: link clock period 6 ns; a pause of 1000 ns covers the core's crossing and settling
// Notes: sclk stands still and low outside frames; frames are never sent back to back
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output logic sclk,
  output logic selB,
  output logic mosi,
  input wire logic miso,
  input wire logic misoOe
);
  logic lastBit; // last level the device drove
  // a released line must not look like a valid bit, so it shows the inverse
  wire logic misoLine = misoOe ? miso : ~lastBit;

  // idle levels at time zero
  initial
  begin
    sclk = 1'b0;
    selB = 1'b1;
    mosi = 1'b0;
    lastBit = 1'b0;
  end

  // remember what the device drove
  always @(posedge sclk)
    if (misoOe)
      lastBit <= miso;

  // one frame: write flag, 7-bit address, 8 data bits, msb first
  task automatic frame(input logic wr, input logic [6:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {wr, addr, wdata};
    rdata = 8'h00;
    selB = 1'b1;
    #20 selB = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      mosi = bits[15 - i];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
      // read data is taken at the falling edge after rising edges 9..16
      if (i >= 8)
        rdata = {rdata[6:0], misoLine};
      // the core needs time to fetch read data before edge 9
      if (i == 7 && !wr)
        #1000;
    end
    #3 selB = 1'b1;
    mosi = ~mosi; // released data line does not keep its last value
    #1000;
  endtask
endmodule
`default_nettype wire

/* File: test/transceiver_control_registers_tb.sv */
// Purpose: self-checking bench for the control register bank and its queue
// Assumes: host model owns the serial pins; engine pulses come from here
// Notes: expected values are written out by hand, not read from the design
`timescale 1ns/1ps
`default_nettype none
module transceiver_control_registers_tb;
  import transceiver_regs_pkg::*;
  localparam logic [7:0] REV = 8'hA7; // arbitrary revision value
  logic clock, rst_b, sclk, selB, mosi, miso, misoOe, txMode, engineWrite, engineRead;
  logic chipReset, queueEmpty, queueFull;
  logic [9:0] engineWord, headWord;
  trackValues_t trackValues;
  trims_t trims;
  logic [7:0] q; // last read data
  logic [6:0] addrs [5]; // address table for like registers
  int errTotal = 0;
  int checkCount = 0;

  transceiver_control_registers #(.SILICON_REVISION(REV)) dut (.clock(clock), .rst_b(rst_b), .sclk(sclk),
    .selB(selB), .mosi(mosi), .miso(miso), .misoOe(misoOe), .txMode(txMode), .engineWrite(engineWrite),
    .engineWord(engineWord), .engineRead(engineRead), .trackValues(trackValues), .trims(trims),
    .chipReset(chipReset), .headWord(headWord), .queueEmpty(queueEmpty), .queueFull(queueFull));
  host_model host (.sclk(sclk), .selB(selB), .mosi(mosi), .miso(miso), .misoOe(misoOe));

  // 100 ns core clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    checkCount++;
    if (got !== exp)
    begin
      errTotal++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [6:0] a);
    host.frame(1'b0, a, 8'h00, q);
  endtask

  // one-cycle engine pulse, launched at a falling edge
  task automatic eng(input logic w, input logic r, input logic [9:0] word);
    @(negedge clock);
    engineWrite = w;
    engineRead = r;
    engineWord = word;
    @(negedge clock);
    engineWrite = 1'b0;
    engineRead = 1'b0;
  endtask

  task automatic t_reset;
    chk("trims", {8'h00, 8'h04, 8'h30, 8'h23, 8'h36, 4'h2, 4'h0}, trims);
    chk("chipReset", 0, chipReset);
    rd(ADDR_SCRATCH);
    chk("scratch", 8'hC5, q);
    rd(ADDR_REVISION);
    chk("revision", REV, q);
    rd(ADDR_QCTRL);
    chk("qctrl", 6'h07, q[5:0]);
    rd(ADDR_CRYSTAL_GM_CONTROL);
    chk("crystal_gm_control", 8'h02, q);
  endtask

  task automatic t_regs;
    wr(ADDR_SCRATCH, 8'h3A);
    rd(ADDR_SCRATCH);
    chk("scratch", 8'hC5, q);
    wr(ADDR_REVISION, 8'hFF);
    rd(ADDR_REVISION);
    chk("revision", REV, q);
    wr(ADDR_POWER, 8'h0F);
    rd(ADDR_POWER);
    chk("power", 8'h0F, q);
    chk("powerState", 4'hF, trims.powerState);
    wr(ADDR_CRYSTAL_GM_CONTROL, 8'hF9);
    rd(ADDR_CRYSTAL_GM_CONTROL);
    chk("crystal_gm_control", 8'h09, q);
    chk("gmSetting", 4'h9, trims.gmSetting);
    addrs = '{ADDR_XTAL_CAP, ADDR_VCO_TRIM, ADDR_LO_CURRENT, ADDR_REF_ADJUST, ADDR_RX_MISC};
    for (int i = 0; i < 5; i++)
    begin
      wr(addrs[i], 8'(8'h11 * (i + 1)));
      rd(addrs[i]);
      chk("trimReg", 8'(8'h11 * (i + 1)), q);
    end
    chk("trimOut", 40'h1122334455, trims[47:8]);
    // tracking values are read live from the receiver
    @(negedge clock);
    trackValues = 40'h8192A3B4C5;
    addrs = '{ADDR_TRK_AMP_LO, ADDR_TRK_PHASE_HI, ADDR_TRK_PHASE_LO, ADDR_TRK_FREQ_HI, ADDR_TRK_FREQ_LO};
    for (int i = 0; i < 5; i++)
    begin
      rd(addrs[i]);
      chk("track", trackValues[39 - 8 * i -: 8], q);
    end
    rd(7'h60);
    chk("unmapped", 8'h00, q);
    wr(ADDR_POWER, 8'h00);
  endtask

  // transmit: host fills, engine drains
  task automatic t_tx;
    @(negedge clock);
    txMode = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_QCTRL, 8'(3 - i));
      wr(ADDR_QDATA, 8'(8'hA0 + i));
    end
    chk("full", 1, queueFull);
    rd(ADDR_QCTRL);
    chk("qctrl", 8'hC8, q);
    wr(ADDR_QDATA, 8'hEE);
    rd(ADDR_QCTRL);
    chk("qctrl", 8'hE8, q);
    rd(ADDR_QCTRL);
    chk("qctrl", 8'hC8, q);
    for (int i = 0; i < 4; i++)
    begin
      chk("headWord", {2'(3 - i), 8'(8'hA0 + i)}, headWord);
      eng(1'b0, 1'b1, 10'h000);
    end
    chk("empty", 1, queueEmpty);
    eng(1'b0, 1'b1, 10'h000);
    rd(ADDR_QCTRL);
    chk("qctrl", 6'h14, q[5:0]);
  endtask

  // receive: engine fills, host drains
  task automatic t_rx;
    @(negedge clock);
    txMode = 1'b0;
    for (int i = 0; i < 5; i++)
      eng(1'b1, 1'b0, {2'b10, 8'(8'h50 + i)});
    chk("full", 1, queueFull);
    rd(ADDR_QCTRL);
    chk("qctrl", 6'b101010, q[7:2]);
    for (int i = 0; i < 4; i++)
    begin
      rd(ADDR_QDATA);
      chk("qdata", 8'(8'h50 + i), q);
    end
    rd(ADDR_QDATA);
    rd(ADDR_QCTRL);
    chk("qctrl", 4'b0101, q[5:2]);
  endtask

  // whole-chip reset is held until the host clears it
  task automatic t_chip;
    eng(1'b1, 1'b0, 10'h3FF);
    wr(ADDR_CRYSTAL_GM_CONTROL, 8'h07);
    wr(ADDR_POWER, 8'h83);
    chk("chipReset", 1, chipReset);
    chk("empty", 1, queueEmpty);
    chk("gmPower", 8'h23, trims[7:0]);
    repeat (50) @(negedge clock);
    chk("chipReset", 1, chipReset);
    rd(ADDR_POWER);
    chk("power", 8'h83, q);
    wr(ADDR_POWER, 8'h00);
    chk("chipReset", 0, chipReset);
    rd(ADDR_QCTRL);
    chk("cmd", 2'b11, q[1:0]);
  endtask

  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    rst_b = 1'b0;
    txMode = 1'b0;
    engineWrite = 1'b0;
    engineRead = 1'b0;
    engineWord = 10'h000;
    trackValues = 40'h0;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    repeat (5) @(negedge clock);
    t_reset;
    t_regs;
    t_tx;
    t_rx;
    t_chip;
    endOfTest;
  end

  // about 54 frames of 1.1 us (writes) or 2.1 us (reads); cut a hang well beyond that
  initial
  begin
    #500000;
    errTotal++;
    endOfTest;
  end
endmodule
`default_nettype wire
